// ==== rsc_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the reset source controller
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

`define RSC_REG_ADDR        8'hef
`define RSC_BIT_PIN         0
`define RSC_BIT_PWR         1
`define RSC_BIT_CLK         2
`define RSC_BIT_WDT         3
`define RSC_BIT_SOFT        4
`define RSC_BIT_COMP        5
`define RSC_BIT_FLASH       6
`define RSC_SRC_W           7
`define RSC_LEVEL_MASK      7'h27
`define RSC_FLAGS_POR       8'h02
`define RSC_CLK_PERIOD_NS   50
`define RSC_POR_DELAY_NS    300000
`define RSC_POR_DELAY_CYC   ((`RSC_POR_DELAY_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_MIN_HOLD_CYC    4
`define RSC_CLK_WIN_CYC     16

`endif

// ==== rsc_pkg.sv ====
// Types shared by the reset source controller
package rsc_pkg;
	typedef enum logic [1:0] {
		RSC_ST_POR,
		RSC_ST_RUN,
		RSC_ST_HOLD
	} rsc_state_t;
endpackage

// ==== rsc_clk_if.sv ====
// Link between the controller and its clock loss watcher
`timescale 1ns/10ps
interface rsc_clk_if;
	logic enable;
	logic timeout;
	modport watch (input enable, output timeout);
	modport ctrl  (output enable, input timeout);
endinterface

// ==== rsc_clk_watch.sv ====
// Clock loss watcher: flags a monitored clock stuck high or low
`timescale 1ns/10ps
`include "rsc_cfg.svh"
module rsc_clk_watch #(
	parameter int WIN_CYC = `RSC_CLK_WIN_CYC
) (
	input  wire logic   sys_clk_i,
	input  wire logic   reset_n_i,
	input  wire logic   mon_clk_i,
	rsc_clk_if.watch    watch_if
);
	localparam int CW = $clog2(WIN_CYC + 1);

	logic          m1_r, m2_r, m3_r;
	logic          m1_nxt, m2_nxt, m3_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic          to_r, to_nxt;

	// Two-stage sync, third stage only for edge compare
	always_comb begin
		m1_nxt = mon_clk_i;
		m2_nxt = m1_r;
		m3_nxt = m2_r;
	end

	// Stuck-level counter; disabled detector holds zero
	always_comb begin
		cnt_nxt = cnt_r;
		to_nxt  = 1'b0;
		if (!watch_if.enable || (m2_r != m3_r)) begin
			cnt_nxt = '0;
		end else if (cnt_r < CW'(WIN_CYC)) begin
			cnt_nxt = cnt_r + CW'(1);
		end else begin
			to_nxt = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			m1_r  <= 1'b0;
			m2_r  <= 1'b0;
			m3_r  <= 1'b0;
			cnt_r <= '0;
			to_r  <= 1'b0;
		end else begin
			m1_r  <= m1_nxt;
			m2_r  <= m2_nxt;
			m3_r  <= m3_nxt;
			cnt_r <= cnt_nxt;
			to_r  <= to_nxt;
		end
	end

	assign watch_if.timeout = to_r;
endmodule // rsc_clk_watch

// ==== rsc_top.sv ====
// Reset source controller: collects reset requests and records the cause
// How it works
// - Power-on leaves supply monitor enabled and selected
// - Supply drop drives pin low, holds core
// - Power-fail reset reads power-on flag one
// - Supply reset skips the power-on delay
// - Other resets never touch supply enable or select
// - Monitor disabled blocks flash write grant
// - Low reset pin resets; pin flag set
// - Stuck clock resets when detector enabled
// - Clock-loss flag write sets detector enable
// - Only power-on and supply resets drive the reset pin
// - Enabled comparator low output causes reset
// - Watchdog overflow resets, sets watchdog flag
// - Flash address or security fault resets
// - Writing soft flag forces reset, reads one
// - Writing power-on flag selects supply monitor
// - Reads give causes, writes drive enables
// - Other resets clear the power-on flag
`timescale 1ns/10ps
`include "rsc_cfg.svh"
module rsc_top #(
	parameter int POR_DELAY_CYC = `RSC_POR_DELAY_CYC,
	parameter int CLK_WIN_CYC   = `RSC_CLK_WIN_CYC
) (
	input  wire logic       sys_clk_i,
	input  wire logic       reset_n_i,
	input  wire logic [7:0] sfr_addr_i,
	input  wire logic       sfr_wr_i,
	input  wire logic [7:0] sfr_wdata_i,
	output logic      [7:0] sfr_rdata_o,
	input  wire logic       supply_en_wr_i,
	input  wire logic       supply_en_data_i,
	output logic            supply_watch_enable_o,
	input  wire logic       supply_ok_i,
	input  wire logic       rst_pin_i,
	output logic            rst_pin_o,
	output logic            rst_pin_oe_o,
	input  wire logic       mon_clk_i,
	input  wire logic       comp_out_i,
	input  wire logic       wdt_overflow_i,
	input  wire logic       flash_fault_i,
	input  wire logic       flash_wr_req_i,
	output logic            flash_wr_grant_o,
	output logic            core_reset_n_o
);
	localparam int CW = $clog2(POR_DELAY_CYC + 1);

	rsc_clk_if clk_if ();

	// Clock loss watcher on the monitored clock
	rsc_clk_watch #(
		.WIN_CYC (CLK_WIN_CYC)
	) u_clk_watch (
		.sys_clk_i (sys_clk_i),
		.reset_n_i (reset_n_i),
		.mon_clk_i (mon_clk_i),
		.watch_if  (clk_if.watch)
	);

	// Synchroniser state for pin-side inputs
	logic [2:0] s1_r, s1_nxt;
	logic [2:0] s2_r, s2_nxt;
	logic       pin_s, sup_s, cmp_s;

	// Controller state
	rsc_pkg::rsc_state_t   state_r, state_nxt;
	logic [CW-1:0]         cnt_r, cnt_nxt;
	logic [`RSC_SRC_W-1:0] pend_r, pend_nxt;
	logic [7:0]            flags_r, flags_nxt;
	logic                  sup_sel_r, sup_sel_nxt;
	logic                  sup_en_r, sup_en_nxt;
	logic                  mcd_en_r, mcd_en_nxt;
	logic                  cmp_en_r, cmp_en_nxt;
	logic                  core_n_r, core_n_nxt;
	logic                  oe_r, oe_nxt;
	logic                  pout_r, pout_nxt;
	logic [2:0]            drv_r, drv_nxt;
	logic [7:0]            rdata_r, rdata_nxt;
	logic                  grant_r, grant_nxt;

	// Decoded requests
	logic                  wr_hit;
	logic                  pwr_fail;
	logic                  pin_ev;
	logic [`RSC_SRC_W-1:0] req;
	logic                  lvl_on;

	// Two flops per asynchronous input; first stage read only by second
	always_comb begin
		s1_nxt = {comp_out_i, supply_ok_i, rst_pin_i};
		s2_nxt = s1_r;
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s1_r <= 3'h7;
			s2_r <= 3'h7;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
		end
	end

	assign pin_s = s2_r[0];
	assign sup_s = s2_r[1];
	assign cmp_s = s2_r[2];

	assign clk_if.enable = mcd_en_r;

	// Request decode
	always_comb begin
		wr_hit   = sfr_wr_i && (sfr_addr_i == `RSC_REG_ADDR);
		pwr_fail = sup_en_r && sup_sel_r && !sup_s;
		// Our own drive echoes back through the sync; mask it until it clears
		pin_ev   = !pin_s && !oe_r && (drv_r == 3'h0);
		req                 = '0;
		req[`RSC_BIT_PIN]   = pin_ev;
		req[`RSC_BIT_PWR]   = pwr_fail;
		req[`RSC_BIT_CLK]   = mcd_en_r && clk_if.timeout;
		req[`RSC_BIT_WDT]   = wdt_overflow_i;
		req[`RSC_BIT_SOFT]  = wr_hit && sfr_wdata_i[`RSC_BIT_SOFT] && core_n_r;
		req[`RSC_BIT_COMP]  = cmp_en_r && !cmp_s;
		req[`RSC_BIT_FLASH] = flash_fault_i;
		lvl_on   = |(req & `RSC_LEVEL_MASK);
	end

	// Reset sequencer, cause latch and write side of the register
	always_comb begin
		state_nxt   = state_r;
		cnt_nxt     = cnt_r;
		pend_nxt    = pend_r;
		flags_nxt   = flags_r;
		sup_sel_nxt = sup_sel_r;
		sup_en_nxt  = sup_en_r;
		mcd_en_nxt  = mcd_en_r;
		cmp_en_nxt  = cmp_en_r;
		core_n_nxt  = core_n_r;
		oe_nxt      = oe_r;
		drv_nxt     = {drv_r[1:0], oe_r};
		unique case (state_r)
			rsc_pkg::RSC_ST_POR: begin
				// Full power-on delay only here
				oe_nxt = 1'b1;
				if (cnt_r >= CW'(POR_DELAY_CYC - 1)) begin
					state_nxt  = rsc_pkg::RSC_ST_RUN;
					cnt_nxt    = '0;
					flags_nxt  = `RSC_FLAGS_POR;
					core_n_nxt = 1'b1;
					oe_nxt     = 1'b0;
				end else begin
					cnt_nxt = cnt_r + CW'(1);
				end
			end
			rsc_pkg::RSC_ST_RUN: begin
				// Writes steer enables; read-back is untouched
				if (wr_hit) begin
					sup_sel_nxt = sfr_wdata_i[`RSC_BIT_PWR];
					mcd_en_nxt  = sfr_wdata_i[`RSC_BIT_CLK];
					cmp_en_nxt  = sfr_wdata_i[`RSC_BIT_COMP];
				end
				if (supply_en_wr_i) begin
					sup_en_nxt = supply_en_data_i;
				end
				if (|req) begin
					state_nxt  = rsc_pkg::RSC_ST_HOLD;
					cnt_nxt    = '0;
					pend_nxt   = req;
					core_n_nxt = 1'b0;
					oe_nxt     = pwr_fail;
				end
			end
			rsc_pkg::RSC_ST_HOLD: begin
				// Optional sources fall back to off; supply select kept
				mcd_en_nxt = 1'b0;
				cmp_en_nxt = 1'b0;
				pend_nxt   = pend_r | req;
				oe_nxt     = pwr_fail;
				if (cnt_r < CW'(`RSC_MIN_HOLD_CYC - 1)) begin
					cnt_nxt = cnt_r + CW'(1);
				end else if (!lvl_on) begin
					// Release without power-on delay, even after supply fail
					state_nxt  = rsc_pkg::RSC_ST_RUN;
					cnt_nxt    = '0;
					flags_nxt  = {1'b0, pend_r};
					pend_nxt   = '0;
					core_n_nxt = 1'b1;
				end
			end
		endcase
		pout_nxt = !oe_nxt;
	end

	// Read side shows cause flags; other addresses read zero
	always_comb begin
		rdata_nxt = (sfr_addr_i == `RSC_REG_ADDR) ? flags_r : 8'h00;
		grant_nxt = flash_wr_req_i && sup_en_r && core_n_r;
	end

	// Only the power-on reset touches supply enable and select
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r   <= rsc_pkg::RSC_ST_POR;
			cnt_r     <= '0;
			pend_r    <= '0;
			flags_r   <= 8'h00;
			sup_sel_r <= 1'b1;
			sup_en_r  <= 1'b1;
			mcd_en_r  <= 1'b0;
			cmp_en_r  <= 1'b0;
			core_n_r  <= 1'b0;
			oe_r      <= 1'b1;
			pout_r    <= 1'b0;
			drv_r     <= 3'h7;
			rdata_r   <= 8'h00;
			grant_r   <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			cnt_r     <= cnt_nxt;
			pend_r    <= pend_nxt;
			flags_r   <= flags_nxt;
			sup_sel_r <= sup_sel_nxt;
			sup_en_r  <= sup_en_nxt;
			mcd_en_r  <= mcd_en_nxt;
			cmp_en_r  <= cmp_en_nxt;
			core_n_r  <= core_n_nxt;
			oe_r      <= oe_nxt;
			pout_r    <= pout_nxt;
			drv_r     <= drv_nxt;
			rdata_r   <= rdata_nxt;
			grant_r   <= grant_nxt;
		end
	end

	assign sfr_rdata_o           = rdata_r;
	assign supply_watch_enable_o = sup_en_r;
	assign rst_pin_o             = pout_r;
	assign rst_pin_oe_o          = oe_r;
	assign flash_wr_grant_o      = grant_r;
	assign core_reset_n_o        = core_n_r;
endmodule // rsc_top

// ==== rsc_chk.sv ====
// Port checker of the reset source controller
`timescale 1ns/10ps
`include "rsc_cfg.svh"
module rsc_chk (
	input wire logic       sys_clk_i,
	input wire logic       reset_n_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic       sfr_wr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic       supply_en_wr_i,
	input wire logic       supply_watch_enable_o,
	input wire logic       rst_pin_o,
	input wire logic       rst_pin_oe_o,
	input wire logic       wdt_overflow_i,
	input wire logic       flash_fault_i,
	input wire logic       flash_wr_req_i,
	input wire logic       flash_wr_grant_o,
	input wire logic       core_reset_n_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	// Soft force write while running
	wire soft_w = sfr_wr_i && sfr_addr_i == `RSC_REG_ADDR &&
		sfr_wdata_i[`RSC_BIT_SOFT] && core_reset_n_o;
	property p_soft; soft_w |=> !core_reset_n_o; endproperty
	a_soft: assert property (p_soft) else $error("soft write gave no reset");
	property p_hold; $fell(core_reset_n_o) |-> !core_reset_n_o [*4]; endproperty
	a_hold: assert property (p_hold) else $error("reset hold too short");
	property p_grant; flash_wr_grant_o |-> $past(flash_wr_req_i) && $past(supply_watch_enable_o);
	endproperty
	a_grant: assert property (p_grant) else $error("flash write granted");
	property p_supen; !$stable(supply_watch_enable_o) |-> $past(supply_en_wr_i); endproperty
	a_supen: assert property (p_supen) else $error("supply enable changed");
	property p_quiet; soft_w |=> !rst_pin_oe_o [*4]; endproperty
	a_quiet: assert property (p_quiet) else $error("soft reset drove pin");
	property p_wdt; wdt_overflow_i && core_reset_n_o |=> !core_reset_n_o && !rst_pin_oe_o;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog reset wrong");
	property p_flash; flash_fault_i && core_reset_n_o |=> !core_reset_n_o && !rst_pin_oe_o;
	endproperty
	a_flash: assert property (p_flash) else $error("flash fault reset wrong");
	property p_drain; rst_pin_oe_o |-> !rst_pin_o; endproperty
	a_drain: assert property (p_drain) else $error("pin driven high");
	property p_rsvd; !sfr_rdata_o[7]; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
	// Main scenarios reached
	c_soft: cover property (soft_w);
	c_pin: cover property ($rose(rst_pin_oe_o));
	c_grant: cover property (flash_wr_grant_o);
endmodule // rsc_chk
bind rsc_top rsc_chk u_chk (.sys_clk_i, .reset_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i,
	.sfr_rdata_o, .supply_en_wr_i, .supply_watch_enable_o, .rst_pin_o, .rst_pin_oe_o,
	.wdt_overflow_i, .flash_fault_i, .flash_wr_req_i, .flash_wr_grant_o, .core_reset_n_o);

// ==== rsc_pin_model.sv ====
// External reset circuit on the open-drain reset pin
`timescale 1ns/10ps
module rsc_pin_model (
	input  wire logic dev_oe_i,
	input  wire logic dev_o_i,
	input  wire logic push_i,
	output logic      pin_o
);
	// Pull-up wins unless either side pulls low
	assign pin_o = !((dev_oe_i && !dev_o_i) || push_i);
endmodule // rsc_pin_model

// ==== reset_source_controller_tb_top.sv ====
// Self-checking bench of the reset source controller
`timescale 1ns/10ps
`include "rsc_cfg.svh"
module reset_source_controller_tb_top;
	localparam int POR = 20;
	logic       sys_clk_i, reset_n_i, sfr_wr_i, supply_en_wr_i, supply_en_data_i, supply_ok_i;
	logic       rst_pin_i, mon_clk_i, comp_out_i, wdt_overflow_i, flash_fault_i, flash_wr_req_i;
	logic       supply_watch_enable_o, rst_pin_o, rst_pin_oe_o, flash_wr_grant_o, core_reset_n_o;
	logic       push, mon_run;
	logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
	int         bad_count = 0, checks = 0, n;
	rsc_top #(.POR_DELAY_CYC(POR), .CLK_WIN_CYC(16)) dut (.sys_clk_i, .reset_n_i, .sfr_addr_i,
		.sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o, .supply_en_wr_i, .supply_en_data_i,
		.supply_watch_enable_o, .supply_ok_i, .rst_pin_i, .rst_pin_o, .rst_pin_oe_o, .mon_clk_i,
		.comp_out_i, .wdt_overflow_i, .flash_fault_i, .flash_wr_req_i, .flash_wr_grant_o,
		.core_reset_n_o);
	rsc_pin_model u_pin (.dev_oe_i(rst_pin_oe_o), .dev_o_i(rst_pin_o), .push_i(push),
		.pin_o(rst_pin_i));
	// Clocks; the watched clock stops only when asked
	initial begin
		sys_clk_i = 1'b0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) if (mon_run) mon_clk_i <= ~mon_clk_i;
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk_i);
	endtask
	task automatic wr(input logic [7:0] d);
		@(posedge sys_clk_i);
		sfr_addr_i <= `RSC_REG_ADDR;
		sfr_wr_i <= 1'b1;
		sfr_wdata_i <= d;
		@(posedge sys_clk_i);
		sfr_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		sfr_addr_i <= a;
		tick(2);
		chk(sfr_rdata_o, exp);
	endtask
	// Bounded wait for the core to leave reset
	task automatic go(input int k);
		tick(k);
		n = 0;
		while (core_reset_n_o !== 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		// A core that never leaves reset is a failure, not a silent pass
		if (core_reset_n_o !== 1'b1) bad_count++;
		tick(1);
	endtask
	task automatic sup(input logic v);
		supply_en_data_i <= v;
		supply_en_wr_i <= 1'b1;
		tick(1);
		supply_en_wr_i <= 1'b0;
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Hang guard, far beyond the roughly 160 cycles needed
	initial begin
		tick(3000);
		bad_count++;
		wrap_up;
	end
	// Main sequence
	initial begin
		{reset_n_i, sfr_wr_i, supply_en_wr_i, supply_en_data_i, mon_clk_i, push} = 6'h00;
		{supply_ok_i, mon_run, comp_out_i, wdt_overflow_i, flash_fault_i} = 5'h1c;
		{flash_wr_req_i, sfr_addr_i, sfr_wdata_i} = 17'h00000;
		tick(10);
		reset_n_i <= 1'b1;
		go(1);
		rd(`RSC_REG_ADDR, 8'h02);
		chk({7'h00, supply_watch_enable_o}, 8'h01);
		rd(8'h00, 8'h00);
		// Bit 1 kept set so the supply monitor stays selected
		wr(8'h12);
		go(3);
		rd(`RSC_REG_ADDR, 8'h10);
		for (int i = 0; i < 2; i++) begin
			wdt_overflow_i <= (i == 0);
			flash_fault_i <= (i == 1);
			tick(1);
			{wdt_overflow_i, flash_fault_i} <= 2'h0;
			go(3);
			rd(`RSC_REG_ADDR, i ? 8'h40 : 8'h08);
		end
		push <= 1'b1;
		tick(8);
		push <= 1'b0;
		go(1);
		rd(`RSC_REG_ADDR, 8'h01);
		wr(8'h06);
		rd(`RSC_REG_ADDR, 8'h01);
		mon_run <= 1'b0;
		tick(30);
		mon_run <= 1'b1;
		go(4);
		rd(`RSC_REG_ADDR, 8'h04);
		// Comparator output has sat high since start, so enabling is safe
		wr(8'h22);
		comp_out_i <= 1'b0;
		// Let the comparator level cross the sync so both land on one edge
		tick(2);
		wdt_overflow_i <= 1'b1;
		tick(1);
		wdt_overflow_i <= 1'b0;
		tick(5);
		comp_out_i <= 1'b1;
		go(1);
		rd(`RSC_REG_ADDR, 8'h28);
		supply_ok_i <= 1'b0;
		tick(5);
		chk({7'h00, rst_pin_oe_o}, 8'h01);
		chk({5'h00, core_reset_n_o, rst_pin_oe_o, rst_pin_o}, 8'h02);
		supply_ok_i <= 1'b1;
		go(0);
		chk({7'h00, n < POR}, 8'h01);
		rd(`RSC_REG_ADDR, 8'h02);
		sup(1'b0);
		flash_wr_req_i <= 1'b1;
		tick(2);
		chk({7'h00, flash_wr_grant_o}, 8'h00);
		wr(8'h10);
		go(3);
		chk({7'h00, supply_watch_enable_o}, 8'h00);
		sup(1'b1);
		// Enable first, then select the monitor as a source
		wr(8'h02);
		tick(2);
		chk({7'h00, flash_wr_grant_o}, 8'h01);
		wrap_up;
	end
endmodule // reset_source_controller_tb_top
